/* logic/dtc_timer_pair.sv */
// two general timers with overflow flags, mode control and timer interrupt gating
// assumes a single-cycle sfr write strobe and read strobe from the cpu core
`timescale 1ns/1ps
module dtc_timer_pair (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic timer_zero_irq_ack,
  input wire logic timer_one_irq_ack,
  output logic timer_zero_irq_req,
  output logic timer_one_irq_req,
  output logic timer_zero_irq_priority,
  output logic timer_one_irq_priority,
  output logic global_irq_enable,
  output logic timer_one_baud_tick
);
  import dtc_pkg::*;

  dtc_tick_if tick_bus ();

  dtc_prescaler #(
    .DIV(DTC_PRESCALE_DIV)
  ) u_prescaler (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tk(tick_bus.src)
  );

  logic [7:0] timer_zero_low_byte;
  logic [7:0] timer_zero_high_byte;
  logic [7:0] timer_one_low_byte;
  logic [7:0] timer_one_high_byte;
  logic timer_zero_overflow_flag;
  logic timer_one_overflow_flag;
  logic timer_zero_run;
  logic timer_one_run;
  logic [1:0] ext_flags;
  dtc_mode_t timer_zero_mode_field;
  dtc_mode_t timer_one_mode_field;
  logic timer_zero_irq_enable;
  logic timer_one_irq_enable;
  logic [1:0] ext_irq_enable;
  logic [1:0] ext_irq_priority;

  logic wr_ctrl;
  logic wr_mode;
  logic wr_t0_lo;
  logic wr_t0_hi;
  logic wr_t1_lo;
  logic wr_t1_hi;
  logic wr_ien;
  logic wr_pri;
  logic tick;

  logic t0_split;
  logic t0_low_adv;
  logic t0_high_adv;
  logic t1_adv;
  logic [16:0] t0_next;
  logic [16:0] t1_next;
  logic [7:0] t0_split_lo;
  logic [7:0] t0_split_hi;
  logic t0_split_lo_ovf;
  logic t0_split_hi_ovf;
  logic t0_ovf;
  logic t1_ovf;
  logic set_t0_flag;
  logic set_t1_flag;
  logic [7:0] ctrl_view;
  logic [7:0] mode_view;
  logic [7:0] ien_view;
  logic [7:0] pri_view;
  logic [7:0] next_rdata;
  logic next_hit;

  assign tick = tick_bus.tick;

  assign wr_ctrl = sfr_wr && (sfr_addr == DTC_ADDR_CTRL);
  assign wr_mode = sfr_wr && (sfr_addr == DTC_ADDR_MODE);
  assign wr_t0_lo = sfr_wr && (sfr_addr == DTC_ADDR_T0_LO);
  assign wr_t0_hi = sfr_wr && (sfr_addr == DTC_ADDR_T0_HI);
  assign wr_t1_lo = sfr_wr && (sfr_addr == DTC_ADDR_T1_LO);
  assign wr_t1_hi = sfr_wr && (sfr_addr == DTC_ADDR_T1_HI);
  assign wr_ien = sfr_wr && (sfr_addr == DTC_ADDR_IRQ_EN);
  assign wr_pri = sfr_wr && (sfr_addr == DTC_ADDR_IRQ_PRI);

  // one step of a timer in modes 0..2; returns {overflow, high, low}
  function automatic logic [16:0] dtc_step(
    input dtc_mode_t mode,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [13:0] sum13;
    logic [16:0] sum16;
    logic [16:0] res;
    sum13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    sum16 = {1'b0, hi, lo} + 17'h00001;
    res = {1'b0, hi, lo};
    case (mode)
      DTC_MODE_13BIT: begin
        // upper three low-byte bits are left as stored; software masks them
        res = {sum13[13], sum13[12:5], lo[7:5], sum13[4:0]};
      end
      DTC_MODE_16BIT: begin
        res = sum16;
      end
      DTC_MODE_RELOAD8: begin
        if (lo == DTC_BYTE_ALL_ONES) begin
          res = {1'b1, hi, hi};
        end else begin
          res = {1'b0, hi, lo + 8'h01};
        end
      end
      default: begin
        res = {1'b0, hi, lo};
      end
    endcase
    return res;
  endfunction

  assign t0_split = (timer_zero_mode_field == DTC_MODE_SPLIT);

  // no gate or external count path exists: the run bits and mode fields alone enable counting
  assign t0_low_adv = tick && timer_zero_run;
  assign t0_high_adv = tick && timer_one_run && t0_split;
  // in split, timer one ignores its run bit and follows its mode field only
  always_comb begin
    if (t0_split) begin
      t1_adv = tick && (timer_one_mode_field != DTC_MODE_SPLIT);
    end else begin
      t1_adv = tick && timer_one_run && (timer_one_mode_field != DTC_MODE_SPLIT);
    end
  end

  assign t0_next = dtc_step(timer_zero_mode_field, timer_zero_low_byte, timer_zero_high_byte);
  assign t1_next = dtc_step(timer_one_mode_field, timer_one_low_byte, timer_one_high_byte);

  // split halves are plain 8-bit up counters
  assign {t0_split_lo_ovf, t0_split_lo} = {1'b0, timer_zero_low_byte} + 9'h001;
  assign {t0_split_hi_ovf, t0_split_hi} = {1'b0, timer_zero_high_byte} + 9'h001;

  assign t0_ovf = t0_split ? t0_split_lo_ovf : t0_next[16];
  assign t1_ovf = t1_next[16];

  // a byte write takes priority over a count step in the same cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_zero_low_byte <= DTC_RST_BYTE;
    end else if (wr_t0_lo) begin
      timer_zero_low_byte <= sfr_wdata;
    end else if (t0_low_adv) begin
      timer_zero_low_byte <= t0_split ? t0_split_lo : t0_next[7:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_zero_high_byte <= DTC_RST_BYTE;
    end else if (wr_t0_hi) begin
      timer_zero_high_byte <= sfr_wdata;
    end else if (t0_high_adv) begin
      timer_zero_high_byte <= t0_split_hi;
    end else if (t0_low_adv && !t0_split) begin
      timer_zero_high_byte <= t0_next[15:8];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_one_low_byte <= DTC_RST_BYTE;
    end else if (wr_t1_lo) begin
      timer_one_low_byte <= sfr_wdata;
    end else if (t1_adv) begin
      timer_one_low_byte <= t1_next[7:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_one_high_byte <= DTC_RST_BYTE;
    end else if (wr_t1_hi) begin
      timer_one_high_byte <= sfr_wdata;
    end else if (t1_adv) begin
      timer_one_high_byte <= t1_next[15:8];
    end
  end

  // flag sources; the timer one flag belongs to the split high byte in mode 3
  assign set_t0_flag = t0_low_adv && t0_ovf;
  always_comb begin
    if (t0_split) begin
      set_t1_flag = t0_high_adv && t0_split_hi_ovf;
    end else begin
      set_t1_flag = t1_adv && t1_ovf;
    end
  end

  // baud source keeps ticking from timer one even while split borrows its flag
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_one_baud_tick <= 1'b0;
    end else begin
      timer_one_baud_tick <= t1_adv && t1_ovf;
    end
  end

  // set wins over a software clear or a service acknowledge in the same cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_zero_overflow_flag <= DTC_RST_CTRL[DTC_CTRL_T0_FLAG];
    end else if (set_t0_flag) begin
      timer_zero_overflow_flag <= 1'b1;
    end else if (timer_zero_irq_ack) begin
      timer_zero_overflow_flag <= 1'b0;
    end else if (wr_ctrl) begin
      timer_zero_overflow_flag <= sfr_wdata[DTC_CTRL_T0_FLAG];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_one_overflow_flag <= DTC_RST_CTRL[DTC_CTRL_T1_FLAG];
    end else if (set_t1_flag) begin
      timer_one_overflow_flag <= 1'b1;
    end else if (timer_one_irq_ack) begin
      timer_one_overflow_flag <= 1'b0;
    end else if (wr_ctrl) begin
      timer_one_overflow_flag <= sfr_wdata[DTC_CTRL_T1_FLAG];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_zero_run <= DTC_RST_CTRL[DTC_CTRL_T0_RUN];
      timer_one_run <= DTC_RST_CTRL[DTC_CTRL_T1_RUN];
      ext_flags <= {DTC_RST_CTRL[DTC_CTRL_EXT1_FLAG], DTC_RST_CTRL[DTC_CTRL_EXT0_FLAG]};
    end else if (wr_ctrl) begin
      timer_zero_run <= sfr_wdata[DTC_CTRL_T0_RUN];
      timer_one_run <= sfr_wdata[DTC_CTRL_T1_RUN];
      // external interrupt flags are not driven here; kept as plain storage
      ext_flags <= {sfr_wdata[DTC_CTRL_EXT1_FLAG], sfr_wdata[DTC_CTRL_EXT0_FLAG]};
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_one_mode_field <= dtc_mode_t'(DTC_RST_MODE[DTC_MODE_T1_LSB +: 2]);
      timer_zero_mode_field <= dtc_mode_t'(DTC_RST_MODE[DTC_MODE_T0_LSB +: 2]);
    end else if (wr_mode) begin
      timer_one_mode_field <= dtc_mode_t'(sfr_wdata[DTC_MODE_T1_LSB +: 2]);
      timer_zero_mode_field <= dtc_mode_t'(sfr_wdata[DTC_MODE_T0_LSB +: 2]);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      global_irq_enable <= DTC_RST_IRQ_EN[DTC_IEN_GLOBAL];
      timer_one_irq_enable <= DTC_RST_IRQ_EN[DTC_IEN_T1];
      timer_zero_irq_enable <= DTC_RST_IRQ_EN[DTC_IEN_T0];
      ext_irq_enable <= {DTC_RST_IRQ_EN[2], DTC_RST_IRQ_EN[0]};
    end else if (wr_ien) begin
      global_irq_enable <= sfr_wdata[DTC_IEN_GLOBAL];
      timer_one_irq_enable <= sfr_wdata[DTC_IEN_T1];
      timer_zero_irq_enable <= sfr_wdata[DTC_IEN_T0];
      ext_irq_enable <= {sfr_wdata[2], sfr_wdata[0]};
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_one_irq_priority <= DTC_RST_IRQ_PRI[DTC_PRI_T1];
      timer_zero_irq_priority <= DTC_RST_IRQ_PRI[DTC_PRI_T0];
      ext_irq_priority <= {DTC_RST_IRQ_PRI[2], DTC_RST_IRQ_PRI[0]};
    end else if (wr_pri) begin
      timer_one_irq_priority <= sfr_wdata[DTC_PRI_T1];
      timer_zero_irq_priority <= sfr_wdata[DTC_PRI_T0];
      ext_irq_priority <= {sfr_wdata[2], sfr_wdata[0]};
    end
  end

  // global enable is ANDed with the per-timer enables
  assign timer_zero_irq_req = global_irq_enable && timer_zero_irq_enable
                              && timer_zero_overflow_flag;
  assign timer_one_irq_req = global_irq_enable && timer_one_irq_enable
                             && timer_one_overflow_flag;

  always_comb begin
    ctrl_view = DTC_CTRL_FIXED_MASK;
    ctrl_view[DTC_CTRL_T1_FLAG] = timer_one_overflow_flag;
    ctrl_view[DTC_CTRL_T1_RUN] = timer_one_run;
    ctrl_view[DTC_CTRL_T0_FLAG] = timer_zero_overflow_flag;
    ctrl_view[DTC_CTRL_T0_RUN] = timer_zero_run;
    ctrl_view[DTC_CTRL_EXT1_FLAG] = ext_flags[1];
    ctrl_view[DTC_CTRL_EXT0_FLAG] = ext_flags[0];
  end

  always_comb begin
    mode_view = 8'h00;
    mode_view[DTC_MODE_T1_LSB +: 2] = timer_one_mode_field;
    mode_view[DTC_MODE_T0_LSB +: 2] = timer_zero_mode_field;
  end

  always_comb begin
    ien_view = 8'h00;
    ien_view[DTC_IEN_GLOBAL] = global_irq_enable;
    ien_view[DTC_IEN_T1] = timer_one_irq_enable;
    ien_view[2] = ext_irq_enable[1];
    ien_view[DTC_IEN_T0] = timer_zero_irq_enable;
    ien_view[0] = ext_irq_enable[0];
  end

  always_comb begin
    pri_view = 8'h00;
    pri_view[DTC_PRI_T1] = timer_one_irq_priority;
    pri_view[2] = ext_irq_priority[1];
    pri_view[DTC_PRI_T0] = timer_zero_irq_priority;
    pri_view[0] = ext_irq_priority[0];
  end

  // count bytes read back live, so software sees split-mode timer one too
  always_comb begin
    next_hit = 1'b1;
    case (sfr_addr)
      DTC_ADDR_CTRL: next_rdata = ctrl_view;
      DTC_ADDR_MODE: next_rdata = mode_view & DTC_MODE_MASK;
      DTC_ADDR_T0_LO: next_rdata = timer_zero_low_byte;
      DTC_ADDR_T1_LO: next_rdata = timer_one_low_byte;
      DTC_ADDR_T0_HI: next_rdata = timer_zero_high_byte;
      DTC_ADDR_T1_HI: next_rdata = timer_one_high_byte;
      DTC_ADDR_IRQ_EN: next_rdata = ien_view & DTC_IEN_MASK;
      DTC_ADDR_IRQ_PRI: next_rdata = pri_view & DTC_PRI_MASK;
      default: begin
        next_rdata = 8'h00;
        next_hit = 1'b0;
      end
    endcase
  end

  // read data registered one cycle after the strobe; held until the next read
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
      sfr_hit <= 1'b0;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
      sfr_hit <= next_hit;
    end else begin
      sfr_hit <= 1'b0;
    end
  end

endmodule

/* logic/dtc_pkg.sv */
// constants, field positions and mode encodings of the dual timer block
// assumes a single mclk domain and the cpu special-function-register port
// Contract
// - both timers advance once every twelve system clocks
// - mode 0 counts thirteen bits: high byte plus low five low-byte bits
// - mode 0 wraps from all ones to zero and sets the overflow flag
// - mode 1 counts sixteen bits, wraps from FFFF to zero, sets flag
// - mode 2 low byte counts; on FF it reloads from the high byte
// - only the run bits and mode fields gate counting; external gate and count inputs inactive
// - timer zero mode 3 splits into two bytes; timer one mode 3 holds
// - split low byte uses timer zero run bit and overflow flag
// - split high byte counts clock/12 under timer one run, sets its flag
// - in split, timer one runs in modes 0..2, stops in mode 3
// - in split, timer one overflow raises no interrupt
// - in split, timer one still gives baud overflow; bytes stay readable
// - mode register: timer one mode bits 5:4, timer zero bits 1:0
// - control register bit 7 and bit 5 are hardware-set overflow flags
// - control bit 4 runs timer zero, bit 6 timer one or split high byte
// - global enable bit 7 masks all requests when zero
// - enable bits 3 and 1 let the overflow flags request interrupts
// - priority bits 3 and 1 choose high priority for each timer
package dtc_pkg;

  localparam logic [7:0] DTC_ADDR_CTRL = 8'h88;
  localparam logic [7:0] DTC_ADDR_MODE = 8'h89;
  localparam logic [7:0] DTC_ADDR_T0_LO = 8'h8A;
  localparam logic [7:0] DTC_ADDR_T1_LO = 8'h8B;
  localparam logic [7:0] DTC_ADDR_T0_HI = 8'h8C;
  localparam logic [7:0] DTC_ADDR_T1_HI = 8'h8D;
  localparam logic [7:0] DTC_ADDR_IRQ_EN = 8'hA8;
  localparam logic [7:0] DTC_ADDR_IRQ_PRI = 8'hB8;

  localparam logic [7:0] DTC_RST_CTRL = 8'h05;
  localparam logic [7:0] DTC_RST_MODE = 8'h00;
  localparam logic [7:0] DTC_RST_BYTE = 8'h00;
  localparam logic [7:0] DTC_RST_IRQ_EN = 8'h00;
  localparam logic [7:0] DTC_RST_IRQ_PRI = 8'h00;

  // control register fields
  localparam int DTC_CTRL_T1_FLAG = 7;
  localparam int DTC_CTRL_T1_RUN = 6;
  localparam int DTC_CTRL_T0_FLAG = 5;
  localparam int DTC_CTRL_T0_RUN = 4;
  localparam int DTC_CTRL_EXT1_FLAG = 3;
  localparam int DTC_CTRL_EXT0_FLAG = 1;
  // bits 2 and 0 are unused and read back as their reset ones
  localparam logic [7:0] DTC_CTRL_FIXED_MASK = 8'h05;

  // mode register fields
  localparam int DTC_MODE_T1_LSB = 4;
  localparam int DTC_MODE_T0_LSB = 0;
  localparam logic [7:0] DTC_MODE_MASK = 8'h33;

  // interrupt enable and priority fields
  localparam int DTC_IEN_GLOBAL = 7;
  localparam int DTC_IEN_T1 = 3;
  localparam int DTC_IEN_T0 = 1;
  localparam logic [7:0] DTC_IEN_MASK = 8'h8F;
  localparam int DTC_PRI_T1 = 3;
  localparam int DTC_PRI_T0 = 1;
  localparam logic [7:0] DTC_PRI_MASK = 8'h0F;

  localparam int DTC_PRESCALE_DIV = 12;
  localparam logic [7:0] DTC_BYTE_ALL_ONES = 8'hFF;

  typedef enum logic [1:0] {
    DTC_MODE_13BIT = 2'b00,
    DTC_MODE_16BIT = 2'b01,
    DTC_MODE_RELOAD8 = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_t;

endpackage

/* logic/dtc_tick_if.sv */
// carrier for the count tick between the prescaler and the timer core
// assumes both ends run on mclk
`timescale 1ns/1ps
interface dtc_tick_if;
  logic tick;
  logic [3:0] phase;
  modport src (output tick, output phase);
  modport snk (input tick, input phase);
endinterface

/* logic/dtc_prescaler.sv */
// free-running divider that makes the shared count tick
// assumes mclk is the system clock; no gating of its own
`timescale 1ns/1ps
module dtc_prescaler #(
  parameter int DIV = dtc_pkg::DTC_PRESCALE_DIV
) (
  input wire logic mclk,
  input wire logic sys_rst,
  dtc_tick_if.src tk
);
  import dtc_pkg::*;

  localparam logic [3:0] LAST = 4'(DIV - 1);

  logic [3:0] count;

  // free running so both timers share one phase; run bits gate at the counters
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 4'h0;
    end else if (count == LAST) begin
      count <= 4'h0;
    end else begin
      count <= count + 4'h1;
    end
  end

  assign tk.tick = (count == LAST);
  assign tk.phase = count;

endmodule

/* tb/dtc_timer_pair_asserts.sv */
// concurrent checks on the sfr port and the timer interrupt outputs
// assumes one mclk domain and an active-high asynchronous sys_rst
`timescale 1ns/1ps
module dtc_timer_pair_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic timer_zero_irq_req,
  input wire logic timer_one_irq_req,
  input wire logic timer_zero_irq_priority,
  input wire logic timer_one_irq_priority,
  input wire logic global_irq_enable,
  input wire logic timer_one_baud_tick
);
  import dtc_pkg::*;
  logic addr_mapped;
  assign addr_mapped = sfr_addr inside {DTC_ADDR_CTRL, DTC_ADDR_MODE, DTC_ADDR_T0_LO,
    DTC_ADDR_T1_LO, DTC_ADDR_T0_HI, DTC_ADDR_T1_HI, DTC_ADDR_IRQ_EN, DTC_ADDR_IRQ_PRI};
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_zero_irq_masked: assert property (
    timer_zero_irq_req |-> global_irq_enable) else $error("timer zero request while masked");
  a_one_irq_masked: assert property (
    timer_one_irq_req |-> global_irq_enable) else $error("timer one request while masked");
  a_mapped_read_hit: assert property (
    sfr_rd && addr_mapped |=> sfr_hit) else $error("mapped read gave no hit");
  a_unmapped_read_zero: assert property (
    sfr_rd && !addr_mapped |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read not refused");
  a_read_data_holds: assert property (
    !sfr_rd |=> $stable(sfr_rdata) && !sfr_hit) else $error("read data moved without read");
  a_global_enable_write: assert property (
    sfr_wr && sfr_addr == DTC_ADDR_IRQ_EN |=> global_irq_enable == $past(sfr_wdata[7]))
    else $error("global enable not written");
  a_priority_write: assert property (
    sfr_wr && sfr_addr == DTC_ADDR_IRQ_PRI |=> timer_zero_irq_priority == $past(sfr_wdata[1])
    && timer_one_irq_priority == $past(sfr_wdata[3])) else $error("priority bits not written");
  a_priority_kept: assert property (
    !(sfr_wr && sfr_addr == DTC_ADDR_IRQ_PRI) |=> $stable(timer_zero_irq_priority)
    && $stable(timer_one_irq_priority)) else $error("priority changed without write");
  a_baud_tick_spacing: assert property (
    timer_one_baud_tick |=> (!timer_one_baud_tick) [*8]) else $error("baud ticks too close");
endmodule

bind dtc_timer_pair dtc_timer_pair_asserts u_dtc_timer_pair_asserts (.mclk(mclk),
  .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
  .timer_zero_irq_req(timer_zero_irq_req), .timer_one_irq_req(timer_one_irq_req),
  .timer_zero_irq_priority(timer_zero_irq_priority),
  .timer_one_irq_priority(timer_one_irq_priority), .global_irq_enable(global_irq_enable),
  .timer_one_baud_tick(timer_one_baud_tick));

/* tb/dual_timer_counter_modes_test.sv */
// self-checking bench for the dual timer through its sfr port
// assumes the design's own prescaler; all waits are bounded
`timescale 1ns/1ps
module dual_timer_counter_modes_test;
  import dtc_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic timer_zero_irq_ack = 1'b0;
  logic timer_one_irq_ack = 1'b0;
  logic [7:0] sfr_rdata;
  logic sfr_hit, timer_zero_irq_req, timer_one_irq_req;
  logic timer_zero_irq_priority, timer_one_irq_priority, global_irq_enable;
  logic timer_one_baud_tick;
  int n_errors = 0;
  int samples_checked = 0;
  int n;
  logic [7:0] addrs [8] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hA8, 8'hB8};
  logic [7:0] his [7] = '{8'hFF, 8'hFF, 8'h80, 8'h33, 8'hFF, 8'hFF, 8'h80};
  logic [7:0] elos [7] = '{8'hE0, 8'h00, 8'h80, 8'h00, 8'hE0, 8'h00, 8'h80};
  logic [7:0] ehis [7] = '{8'h00, 8'h00, 8'h80, 8'h33, 8'h00, 8'h00, 8'h80};

  always #12.5 mclk = ~mclk;

  dtc_timer_pair u_dtc_timer_pair (.mclk(mclk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .timer_zero_irq_ack(timer_zero_irq_ack),
    .timer_one_irq_ack(timer_one_irq_ack), .timer_zero_irq_req(timer_zero_irq_req),
    .timer_one_irq_req(timer_one_irq_req), .timer_zero_irq_priority(timer_zero_irq_priority),
    .timer_one_irq_priority(timer_one_irq_priority), .global_irq_enable(global_irq_enable),
    .timer_one_baud_tick(timer_one_baud_tick));

  task automatic results();
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge mclk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    #1;
    check(what, sfr_rdata, exp);
  endtask

  task automatic ack(input int t);
    @(posedge mclk);
    if (t == 0) timer_zero_irq_ack <= 1'b1;
    else timer_one_irq_ack <= 1'b1;
    @(posedge mclk);
    timer_zero_irq_ack <= 1'b0;
    timer_one_irq_ack <= 1'b0;
  endtask

  // sel 0 and 1 wait on the requests, 2 on the baud tick; cnt counts cycles
  task automatic wait_for(input int sel, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (hit !== 1'b1) begin
      @(posedge mclk);
      #1;
      cnt++;
      hit = (sel == 0) ? timer_zero_irq_req : (sel == 1) ? timer_one_irq_req
        : timer_one_baud_tick;
      if (cnt > 200) begin
        n_errors++;
        $display("unexpected timeout on event %0d", sel);
        results();
      end
    end
  endtask

  // preload, run to one wrap, stop at once so the next tick cannot blur the result
  task automatic wrap_run(input int t, input logic [1:0] m, input logic [7:0] hi,
                          input logic [7:0] elo, input logic [7:0] ehi);
    logic [7:0] off, flag;
    int cnt;
    off = (t == 1) ? 8'h01 : 8'h00;
    flag = (t == 1) ? 8'h80 : 8'h20;
    wr(DTC_ADDR_MODE, (t == 1) ? {2'b00, m, 4'h0} : {6'h00, m});
    wr(DTC_ADDR_T0_LO + off, 8'hFF);
    wr(DTC_ADDR_T0_HI + off, hi);
    wr(DTC_ADDR_CTRL, (t == 1) ? 8'h40 : 8'h10);
    wait_for(t, cnt);
    wr(DTC_ADDR_CTRL, flag);
    rd_chk("count low", DTC_ADDR_T0_LO + off, elo);
    rd_chk("count high", DTC_ADDR_T0_HI + off, ehi);
    rd_chk("control flag", DTC_ADDR_CTRL, flag | DTC_CTRL_FIXED_MASK);
    ack(t);
    rd_chk("control cleared", DTC_ADDR_CTRL, DTC_CTRL_FIXED_MASK);
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (addrs[i]) rd_chk("reset value", addrs[i], (i == 0) ? 8'h05 : 8'h00);
    check("mapped hit", {7'h00, sfr_hit}, 8'h01);
    wr(8'h90, 8'hFF);
    rd_chk("unmapped", 8'h90, 8'h00);
    check("unmapped hit", {7'h00, sfr_hit}, 8'h00);
    wr(DTC_ADDR_MODE, 8'hFF);
    wr(DTC_ADDR_IRQ_EN, 8'hFF);
    wr(DTC_ADDR_IRQ_PRI, 8'hFF);
    rd_chk("mode reserved", DTC_ADDR_MODE, 8'h33);
    rd_chk("enable reserved", DTC_ADDR_IRQ_EN, 8'h8F);
    rd_chk("priority reserved", DTC_ADDR_IRQ_PRI, 8'h0F);
    check("priorities", {5'h00, timer_one_irq_priority, timer_zero_irq_priority,
      global_irq_enable}, 8'h07);
    wr(DTC_ADDR_IRQ_PRI, 8'h02);
    #1;
    check("priority zero only", {6'h00, timer_one_irq_priority, timer_zero_irq_priority},
      8'h01);
    wr(DTC_ADDR_IRQ_EN, 8'h8A);
    for (int i = 0; i < 7; i++) begin
      wrap_run(i / 4, (i < 4) ? i[1:0] : 2'(i - 4), his[i], elos[i], ehis[i]);
    end
    // masking: mode 2 with reload FF wraps on every tick
    wr(DTC_ADDR_IRQ_EN, 8'h0A);
    wr(DTC_ADDR_T0_HI, 8'hFF);
    // low byte must start at FF, else the first reload is 256 ticks away
    wr(DTC_ADDR_T0_LO, 8'hFF);
    wr(DTC_ADDR_MODE, 8'h02);
    wr(DTC_ADDR_CTRL, 8'h10);
    repeat (30) @(posedge mclk);
    #1;
    check("masked request", {7'h00, timer_zero_irq_req}, 8'h00);
    rd_chk("reload flag", DTC_ADDR_CTRL, 8'h35);
    wr(DTC_ADDR_IRQ_EN, 8'h8A);
    #1;
    check("enabled request", {7'h00, timer_zero_irq_req}, 8'h01);
    wr(DTC_ADDR_IRQ_EN, 8'h88);
    #1;
    check("source disabled", {7'h00, timer_zero_irq_req}, 8'h00);
    wr(DTC_ADDR_CTRL, 8'h20);
    wr(DTC_ADDR_CTRL, 8'h00);
    rd_chk("software clear", DTC_ADDR_CTRL, 8'h05);
    // split: timer one free in mode 2, high byte of timer zero under run one
    wr(DTC_ADDR_T0_LO, 8'h55);
    wr(DTC_ADDR_T0_HI, 8'hFF);
    wr(DTC_ADDR_T1_HI, 8'hFF);
    // timer one low byte left at 80 would need 128 ticks to its first wrap
    wr(DTC_ADDR_T1_LO, 8'hFF);
    wr(DTC_ADDR_MODE, 8'h23);
    wait_for(2, n);
    wait_for(2, n);
    check("baud interval", n[7:0], 8'h0C);
    rd_chk("no timer one flag", DTC_ADDR_CTRL, 8'h05);
    rd_chk("timer one readable", DTC_ADDR_T1_HI, 8'hFF);
    wr(DTC_ADDR_CTRL, 8'h40);
    wait_for(1, n);
    wr(DTC_ADDR_CTRL, 8'h80);
    rd_chk("split high wrap", DTC_ADDR_T0_HI, 8'h00);
    rd_chk("split low idle", DTC_ADDR_T0_LO, 8'h55);
    ack(1);
    wr(DTC_ADDR_CTRL, 8'h40);
    wr(DTC_ADDR_MODE, 8'h33);
    wr(DTC_ADDR_T1_LO, 8'h12);
    repeat (30) @(posedge mclk);
    rd_chk("timer one held", DTC_ADDR_T1_LO, 8'h12);
    results();
  end
endmodule
